// [logic/hamd_consts.svh]
/*
  Constants of the host address mode decoder: offsets, field positions, reset values, window sizes.
  Assumes it is included by its bare name and that the clock runs at 150 MHz.
*/
// Overview of operation
// - direct mode: registers at 2-byte steps from base
// - direct mode decodes a 0x400-byte host window
// - indirect mode: only three registers directly visible
// - indirect mode occupies only 0x06 bytes
// - indirect write: pointer then data window
// - indirect read: pointer then data window returns content
// - bit 0 of config selects indirect mode
// - core clock: 25MHz reference multiplied to 150MHz
// - 2-byte steps on 16-bit bus, 1 on 8-bit
// - multi-byte registers big-endian, low address MSB
// - config register at offset 0x000 in both modes
`ifndef HAMD_CONSTS_SVH
`define HAMD_CONSTS_SVH
`define HAMD_ADDR_W 10
`define HAMD_DATA_W 16
`define HAMD_OFS_CONFIG 10'h000
`define HAMD_OFS_POINTER 10'h002
`define HAMD_OFS_WINDOW 10'h004
`define HAMD_DIRECT_SPAN 11'h400
`define HAMD_INDIRECT_SPAN 11'h006
`define HAMD_SELECT_BIT 0
`define HAMD_CONFIG_RESET 16'h0000
`define HAMD_POINTER_RESET 16'h0000
`define HAMD_RDATA_RESET 16'h0000
`define HAMD_REF_MHZ 25
`define HAMD_CORE_MHZ 150
`define HAMD_BUS16_STEP 2'h2
`define HAMD_BUS8_STEP 2'h1
`endif

// [logic/hamd_decoder.sv]
/*
  Host access front end: decodes host cycles in direct or indirect mode and forwards them to the
  internal register file as one-cycle access strobes with a register offset.
  Assumes the host bus is synchronous to ref_clk, one access per cycle, and the register file
  answers a read with data in the cycle of its strobe (reg_rdata combinational on reg_addr).
*/
`include "hamd_consts.svh"
module hamd_decoder
  import hamd_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // host bus
  input wire logic host_bus16,
  input wire logic host_sel,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [`HAMD_ADDR_W-1:0] host_addr,
  input wire logic [`HAMD_DATA_W-1:0] host_wdata,
  output logic [`HAMD_DATA_W-1:0] host_rdata,
  output logic host_rvalid,
  // internal register file
  output logic reg_wr,
  output logic reg_rd,
  output logic [`HAMD_ADDR_W-1:0] reg_addr,
  output logic [`HAMD_DATA_W-1:0] reg_wdata,
  input wire logic [`HAMD_DATA_W-1:0] reg_rdata,
  // status
  output logic indirect_mode
);

  // ****************************************************
  // state
  // ****************************************************
  logic [`HAMD_DATA_W-1:0] host_access_config;
  logic [`HAMD_DATA_W-1:0] indirect_pointer_reg;
  logic [`HAMD_DATA_W-1:0] next_config;
  logic [`HAMD_DATA_W-1:0] next_pointer;
  logic [`HAMD_DATA_W-1:0] next_rdata;
  logic next_rvalid;
  logic [1:0] lo_byte;
  logic [`HAMD_ADDR_W-1:0] word_addr;
  logic [`HAMD_DATA_W-1:0] wr_word;
  logic in_span;
  logic hit_config;
  logic hit_pointer;
  logic hit_window;
  logic wr_hi;
  logic wr_lo;
  logic cfg_take_hi;
  logic cfg_take_lo;
  logic ptr_take_hi;
  logic ptr_take_lo;
  logic [`HAMD_DATA_W-1:0] cfg_merged;
  logic [`HAMD_DATA_W-1:0] ptr_merged;
  hamd_mode_t mode;

  // ****************************************************
  // access mode
  // ****************************************************
  // core clock of 150 MHz comes from a PLL outside this block; ref_clk stands in for it
  assign mode = host_access_config[`HAMD_SELECT_BIT] ? HAMD_INDIRECT : HAMD_DIRECT;
  assign indirect_mode = (mode == HAMD_INDIRECT);

  // ****************************************************
  // address decode
  // ****************************************************
  always_comb begin
    // on 8-bit bus each byte is its own address; word address drops bit 0
    word_addr = {host_addr[`HAMD_ADDR_W-1:1], 1'b0};
    lo_byte = host_bus16 ? 2'h0 : {1'b0, host_addr[0]};
    case (mode)
      HAMD_DIRECT: in_span = ({1'b0, host_addr} < `HAMD_DIRECT_SPAN);
      HAMD_INDIRECT: in_span = ({1'b0, host_addr} < `HAMD_INDIRECT_SPAN);
      default: in_span = 1'b0;
    endcase
    hit_config = host_sel && in_span && (word_addr == `HAMD_OFS_CONFIG);
    hit_pointer = host_sel && indirect_mode && (word_addr == `HAMD_OFS_POINTER);
    hit_window = host_sel && indirect_mode && (word_addr == `HAMD_OFS_WINDOW);
    // byte lanes: even address is the high byte, big-endian
    wr_hi = host_bus16 || (lo_byte == 2'h0);
    wr_lo = host_bus16 || (lo_byte == 2'h1);
    wr_word = host_wdata;
    if (!host_bus16) begin
      // byte data rides on the low 8 host lines
      wr_word = {host_wdata[7:0], host_wdata[7:0]};
    end
    cfg_take_hi = host_wr && hit_config && wr_hi;
    cfg_take_lo = host_wr && hit_config && wr_lo;
    ptr_take_hi = host_wr && hit_pointer && wr_hi;
    ptr_take_lo = host_wr && hit_pointer && wr_lo;
  end

  // ****************************************************
  // byte lanes of config and pointer
  // ****************************************************
  // each half merges on its own so an 8-bit write leaves the other half alone
  hamd_lane_merge #(
    .LANE_W(8)
  ) cfg_hi_lane_inst (
    .held(host_access_config[15:8]),
    .offered(wr_word[15:8]),
    .take(cfg_take_hi),
    .merged(cfg_merged[15:8])
  );

  hamd_lane_merge #(
    .LANE_W(8)
  ) cfg_lo_lane_inst (
    .held(host_access_config[7:0]),
    .offered(wr_word[7:0]),
    .take(cfg_take_lo),
    .merged(cfg_merged[7:0])
  );

  hamd_lane_merge #(
    .LANE_W(8)
  ) ptr_hi_lane_inst (
    .held(indirect_pointer_reg[15:8]),
    .offered(wr_word[15:8]),
    .take(ptr_take_hi),
    .merged(ptr_merged[15:8])
  );

  hamd_lane_merge #(
    .LANE_W(8)
  ) ptr_lo_lane_inst (
    .held(indirect_pointer_reg[7:0]),
    .offered(wr_word[7:0]),
    .take(ptr_take_lo),
    .merged(ptr_merged[7:0])
  );

  // ****************************************************
  // registers and forwarding
  // ****************************************************
  always_comb begin
    // lanes not taken hold their byte inside the merge units
    next_config = cfg_merged;
    next_pointer = ptr_merged;
    // forwarding: direct mode passes everything else in the window, indirect uses pointer
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    // 8-bit bus keeps the byte address so the register file can pick its lane
    reg_addr = host_bus16 ? word_addr : host_addr;
    reg_wdata = wr_word;
    if (!indirect_mode && host_sel && in_span && !hit_config) begin
      reg_wr = host_wr;
      reg_rd = host_rd;
    end else if (hit_window) begin
      reg_addr = indirect_pointer_reg[`HAMD_ADDR_W-1:0];
      if (!host_bus16) begin
        reg_addr = {indirect_pointer_reg[`HAMD_ADDR_W-1:1], lo_byte[0]};
      end
      reg_wr = host_wr;
      reg_rd = host_rd;
    end
    next_rvalid = host_rd && host_sel;
    next_rdata = `HAMD_RDATA_RESET;
    if (host_rd && hit_config) begin
      next_rdata = host_access_config;
    end else if (host_rd && hit_pointer) begin
      next_rdata = indirect_pointer_reg;
    end else if (reg_rd) begin
      next_rdata = reg_rdata;
    end
    if (!host_bus16) begin
      // pick the addressed byte, MSB at even address
      next_rdata = {8'h00, (lo_byte == 2'h0) ? next_rdata[15:8] : next_rdata[7:0]};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      host_access_config <= `HAMD_CONFIG_RESET;
      indirect_pointer_reg <= `HAMD_POINTER_RESET;
      host_rdata <= `HAMD_RDATA_RESET;
      host_rvalid <= 1'b0;
    end else begin
      host_access_config <= next_config;
      indirect_pointer_reg <= next_pointer;
      host_rdata <= next_rdata;
      host_rvalid <= next_rvalid;
    end
  end

endmodule

// ****************************************************
// byte lane merge
// ****************************************************
module hamd_lane_merge
  import hamd_pkg::*;
#(
  parameter int LANE_W = 8
) (
  // held and offered byte
  input wire logic [LANE_W-1:0] held,
  input wire logic [LANE_W-1:0] offered,
  // lane strobe
  input wire logic take,
  // merged byte
  output logic [LANE_W-1:0] merged
);

  always_comb begin
    merged = held;
    if (take) begin
      merged = offered;
    end
  end

endmodule

// [logic/hamd_pkg.sv]
/*
  Types of the host address mode decoder.
  Assumes nothing of its surroundings.
*/
package hamd_pkg;
  typedef enum logic [1:0] {
    HAMD_DIRECT = 2'h1,
    HAMD_INDIRECT = 2'h2
  } hamd_mode_t;
endpackage

// [verif/hamd_decoder_props.sv]
/* port relations of the decoder
   assumes bound to each hamd_decoder */
`include "hamd_consts.svh"
module hamd_decoder_props (
  input wire logic ref_clk, reset_n, host_bus16, host_sel, host_wr, host_rd,
  input wire logic host_rvalid, reg_wr, reg_rd, indirect_mode,
  input wire logic [`HAMD_ADDR_W-1:0] host_addr, reg_addr,
  input wire logic [`HAMD_DATA_W-1:0] host_wdata, host_rdata, reg_wdata, reg_rdata
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  wire logic rq = host_sel && host_rd;
  wire logic wq = host_sel && host_wr;
  wire logic ind16 = indirect_mode && host_bus16;
  sequence ptr_set; ind16 && wq && host_addr == 10'h002; endsequence
  sequence win_rd; rq && host_addr == 10'h004; endsequence
  AST_RVALID: assert property (rq |=> host_rvalid) else $error("no rvalid");
  AST_RDATA: assert property (host_bus16 && rq && reg_rd |=> host_rdata == $past(reg_rdata)) else $error("rdata");
  AST_DIRECT: assert property (!indirect_mode && host_bus16 && wq && host_addr > 10'h001 && !host_addr[0]
    |-> reg_wr && reg_addr == host_addr && reg_wdata == host_wdata) else $error("direct map");
  AST_CONFIG: assert property (host_sel && host_addr < 10'h002 |-> !reg_wr && !reg_rd) else $error("cfg");
  AST_HIDDEN: assert property (indirect_mode && host_sel && host_addr > 10'h005 |-> !reg_wr && !reg_rd)
    else $error("hidden reg seen");
  AST_MODE: assert property (host_bus16 && wq && host_addr == 10'h000
    |=> indirect_mode == $past(host_wdata[0])) else $error("mode");
  AST_WINDOW: assert property (ptr_set ##1 !wq ##1 win_rd
    |-> reg_rd && reg_addr == $past(host_wdata[9:0], 2)) else $error("window rd");
  AST_WRWIN: assert property (ind16 && wq && host_addr == 10'h004 |-> reg_wr && reg_wdata == host_wdata)
    else $error("window wr");
endmodule
bind hamd_decoder hamd_decoder_props hamd_decoder_props_inst (.*);

// [verif/hamd_regfile_model.sv]
/* internal register file behind the decoder
   assumes combinational strobes and offset */
module hamd_regfile_model (
  input wire logic ref_clk,
  input wire logic reg_wr,
  input wire logic [9:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata
);
  logic [15:0] mem [1024];
  // nonzero fill so a lost read cannot pass as zero
  initial for (int i = 0; i < 1024; i++) mem[i] = {6'h2A, i[9:0]};
  always @(posedge ref_clk) if (reg_wr) mem[reg_addr] <= reg_wdata;
  assign reg_rdata = mem[reg_addr];
endmodule

// [verif/host_address_mode_decoder_test.sv]
/* self-checking bench of the decoder
   assumes the register file model; runs 16-bit then 8-bit host bus */
module host_address_mode_decoder_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 0, reset_n = 0, host_sel = 0, host_wr = 0, host_rd = 0, host_bus16 = 1;
  logic reg_wr, reg_rd, host_rvalid, indirect_mode;
  logic [9:0] host_addr = 10'h000, reg_addr;
  logic [15:0] host_wdata = 16'h0000, host_rdata, reg_wdata, reg_rdata;
  int n_mismatch = 0, checks_done = 0;
  `define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_mismatch++; $display("BAD %0t %h", $time, a); end end
  always #2 ref_clk = ~ref_clk;
  hamd_decoder hamd_decoder_inst (.*);
  hamd_regfile_model hamd_regfile_model_inst (.*);
  task automatic acc(input logic w, input logic [9:0] a, input logic [15:0] d);
    @(negedge ref_clk);
    {host_sel, host_wr, host_rd, host_addr, host_wdata} = {1'b1, w, !w, a, d};
    @(negedge ref_clk);
    {host_sel, host_wr, host_rd} = 3'h0;
  endtask
  task automatic t_direct;
    acc(1, 10'h008, 16'h1234);
    acc(0, 10'h008, 16'h0000);
    `CHK(host_rdata, 16'h1234)
    acc(0, 10'h3FE, 16'h0000);
    `CHK(host_rdata, 16'hABFE)
    acc(0, 10'h000, 16'h0000);
    `CHK(host_rdata, 16'h0000)
    $display("direct done");
  endtask
  task automatic t_indirect;
    acc(1, 10'h000, 16'h0001);
    `CHK(indirect_mode, 1'b1)
    acc(1, 10'h002, 16'h0002);
    acc(1, 10'h004, 16'hFFFF);
    acc(0, 10'h004, 16'h0000);
    `CHK(host_rdata, 16'hFFFF)
    acc(1, 10'h002, 16'h0010);
    acc(0, 10'h004, 16'h0000);
    `CHK(host_rdata, 16'hA810)
    acc(0, 10'h008, 16'h0000);
    `CHK(host_rdata, 16'h0000)
    acc(0, 10'h006, 16'h0000);
    `CHK(host_rdata, 16'h0000)
    acc(1, 10'h000, 16'h0000);
    acc(0, 10'h002, 16'h0000);
    `CHK(host_rdata, 16'hFFFF)
    $display("indirect done");
  endtask
  task automatic t_bus8;
    @(negedge ref_clk);
    host_bus16 = 0;
    acc(1, 10'h001, 16'h0001);
    `CHK(indirect_mode, 1'b1)
    acc(1, 10'h002, 16'h0012);
    acc(1, 10'h003, 16'h0034);
    acc(0, 10'h002, 16'h0000);
    `CHK(host_rdata, 16'h0012)
    acc(0, 10'h003, 16'h0000);
    `CHK(host_rdata, 16'h0034)
    acc(0, 10'h001, 16'h0000);
    `CHK(host_rdata, 16'h0001)
    acc(0, 10'h000, 16'h0000);
    `CHK(host_rdata, 16'h0000)
    $display("bus8 done");
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (16) @(negedge ref_clk);
    reset_n = 1;
    t_direct;
    t_indirect;
    t_bus8;
    close_out;
  end
  // about 60 cycles of traffic; 2000 cycles is ample
  initial begin
    #8000;
    n_mismatch++;
    close_out;
  end
endmodule
